// File: design/dbcm_pkg.sv
// Purpose: shared constants for the debug bus comparator match block
// Assumes: 16-bit address and data bus, one bus cycle per valid strobe
// Notes:   control bits arrive as plain ports, no register map
`default_nettype none
package dbcm_pkg;
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned SIZE_W    = 2;
    // word alignment drops the byte select bit
    localparam int unsigned ALIGN_LSB = 1;
    localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK = 16'hfffe;
    localparam logic [DATA_W-1:0] DATA_ZERO       = 16'h0000;
    // data compare modes
    typedef enum logic {
        DBCM_MATCH_EQUAL,
        DBCM_MATCH_DIFFER
    } dbcm_mode_t;
endpackage
`default_nettype wire

// File: design/dbcm_data_cmp.sv
// Purpose: masked data qualifier for comparator a
// Assumes: mask bit set means the bit is compared
// Notes:   purely combinational
`default_nettype none
module dbcm_data_cmp
    import dbcm_pkg::*;
(
    input  wire logic [DATA_W-1:0] bus_data_in,
    input  wire logic [DATA_W-1:0] ref_data_in,
    input  wire logic [BYTE_W-1:0] data_mask_high_in,
    input  wire logic [BYTE_W-1:0] data_mask_low_in,
    input  wire logic              data_mismatch_select_in,
    output logic                   data_ok_out
);
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] diff;
    // ----------------------------------------
    // masked compare
    // ----------------------------------------
    always_comb begin
        mask = {data_mask_high_in, data_mask_low_in};
        diff = (bus_data_in ^ ref_data_in) & mask;
        if (data_mismatch_select_in == DBCM_MATCH_DIFFER) begin
            // empty mask finds no difference, so never matches
            data_ok_out = (diff != DATA_ZERO);
        end else begin
            // empty mask leaves the address decision alone
            data_ok_out = (diff == DATA_ZERO);
        end
    end
endmodule
`default_nettype wire

// File: design/dbcm_match.sv
// Purpose: inclusive a-b address range match qualified by comparator a
// Assumes: bus inputs synchronous to clk_sys_in, valid for one cycle per access
// Notes:   match outputs are registered, one cycle after the bus cycle
`default_nettype none
module dbcm_match
    import dbcm_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              srst_in,
    input  wire logic              bus_valid_in,
    input  wire logic [ADDR_W-1:0] bus_addr_in,
    input  wire logic [DATA_W-1:0] bus_data_in,
    input  wire logic              bus_read_in,
    input  wire logic              bus_word_in,
    input  wire logic [SIZE_W-1:0] bus_size_in,
    input  wire logic [ADDR_W-1:0] comp_a_addr_in,
    input  wire logic [ADDR_W-1:0] comp_b_addr_in,
    input  wire logic [DATA_W-1:0] comp_a_data_in,
    input  wire logic [BYTE_W-1:0] data_mask_high_in,
    input  wire logic [BYTE_W-1:0] data_mask_low_in,
    input  wire logic              data_mismatch_select_in,
    input  wire logic              comp_a_enable_in,
    input  wire logic              comp_b_enable_in,
    input  wire logic              comp_a_read_select_in,
    input  wire logic              comp_a_direction_qualify_enable_in,
    input  wire logic              comp_b_read_select_in,
    input  wire logic              comp_b_direction_qualify_enable_in,
    input  wire logic              access_size_compare_enable_in,
    input  wire logic [SIZE_W-1:0] access_size_select_in,
    input  wire logic              comp_a_tag_in,
    input  wire logic              comp_b_tag_in,
    input  wire logic              comp_a_immediate_break_request_in,
    input  wire logic              comp_b_immediate_break_request_in,
    output logic                   range_match_out,
    output logic                   tag_request_out,
    output logic                   force_request_out,
    output logic                   break_request_out
);
    logic              data_ok;
    logic [ADDR_W-1:0] addr_eff;
    logic [ADDR_W-1:0] lim_a;
    logic [ADDR_W-1:0] lim_b;
    logic              above_a;
    logic              below_b;
    logic              range_on;
    logic              dir_ok;
    logic              hit;
    logic              range_match_reg;
    logic              range_match_next;
    logic              tag_reg;
    logic              tag_next;
    logic              force_reg;
    logic              force_next;
    logic              brk_reg;
    logic              brk_next;
    logic              unused_b;

    // ----------------------------------------
    // data qualifier
    // ----------------------------------------
    dbcm_data_cmp u_data_cmp (
        .bus_data_in             (bus_data_in),
        .ref_data_in             (comp_a_data_in),
        .data_mask_high_in       (data_mask_high_in),
        .data_mask_low_in        (data_mask_low_in),
        .data_mismatch_select_in (data_mismatch_select_in),
        .data_ok_out             (data_ok)
    );

    // ----------------------------------------
    // range decision
    // ----------------------------------------
    always_comb begin
        // word accesses compare on their aligned address
        addr_eff = bus_word_in ? (bus_addr_in & WORD_ALIGN_MASK) : bus_addr_in;
        // tagged ranges resolve limits to words only, simpler comparators
        lim_a = comp_a_tag_in ? (comp_a_addr_in & WORD_ALIGN_MASK) : comp_a_addr_in;
        lim_b = comp_a_tag_in ? (comp_b_addr_in | ~WORD_ALIGN_MASK) : comp_b_addr_in;
        above_a  = (lim_a <= addr_eff);
        below_b  = (addr_eff <= lim_b);
        range_on = comp_a_enable_in & comp_b_enable_in;
        dir_ok = ~comp_a_direction_qualify_enable_in
               | (bus_read_in == comp_a_read_select_in);
        // size settings never enter the decision in range mode
        hit = bus_valid_in & range_on & above_a & below_b & dir_ok & data_ok;
        range_match_next = hit;
        tag_next   = hit & comp_a_tag_in;
        force_next = hit & ~comp_a_tag_in;
        brk_next   = hit & comp_a_immediate_break_request_in;
    end

    // b-side controls except comp_b_enable_in, and size settings, are deliberately unread
    assign unused_b = comp_b_read_select_in ^ comp_b_direction_qualify_enable_in
                    ^ comp_b_tag_in ^ comp_b_immediate_break_request_in
                    ^ access_size_compare_enable_in ^ (^access_size_select_in)
                    ^ (^bus_size_in) ^ bus_addr_in[ALIGN_LSB-1];

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            range_match_reg <= 1'b0;
            tag_reg         <= 1'b0;
            force_reg       <= 1'b0;
            brk_reg         <= 1'b0;
        end else begin
            range_match_reg <= range_match_next;
            tag_reg         <= tag_next;
            force_reg       <= force_next;
            brk_reg         <= brk_next;
        end
    end

    assign range_match_out   = range_match_reg;
    assign tag_request_out   = tag_reg;
    assign force_request_out = force_reg;
    assign break_request_out = brk_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_hit_cycle;
        bus_valid_in & range_on & above_a & below_b & dir_ok & data_ok;
    endsequence

    a_range_hit_reg: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        s_hit_cycle |=> range_match_out)
        else $error("range hit not registered");
    a_one_side_no: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !(above_a && below_b) |=> !range_match_out)
        else $error("match with one limit only");
    a_enable_pair: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !(comp_a_enable_in && comp_b_enable_in) |=> !range_match_out)
        else $error("match with range disabled");
    a_diff_empty: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (data_mismatch_select_in && data_mask_high_in == '0 && data_mask_low_in == '0)
        |=> !range_match_out)
        else $error("difference match with empty mask");
    a_equal_empty: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (!data_mismatch_select_in && data_mask_high_in == '0 && data_mask_low_in == '0
         && bus_valid_in && range_on && above_a && below_b && dir_ok) |=> range_match_out)
        else $error("empty mask blocked address match");
    a_dir_qualify: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (comp_a_direction_qualify_enable_in && bus_read_in != comp_a_read_select_in)
        |=> !range_match_out)
        else $error("direction mismatch matched");
    a_tag_force: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        range_match_out |-> (tag_request_out != force_request_out)
        && (tag_request_out == $past(comp_a_tag_in)))
        else $error("tag or force wrong");
    a_break_src: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        break_request_out == (range_match_out && $past(comp_a_immediate_break_request_in)))
        else $error("break not from comparator a");
    a_data_equal: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (!data_mismatch_select_in && ((bus_data_in ^ comp_a_data_in)
         & {data_mask_high_in, data_mask_low_in}) != '0) |=> !range_match_out)
        else $error("equal mode matched on differing bit");

    // ----------------------------------------
    // reference checks from the port values
    // ----------------------------------------
    // rebuilt from inputs only, so a broken internal term cannot hide itself
    sequence s_plain_range;
        bus_valid_in && comp_a_enable_in && comp_b_enable_in && !comp_a_tag_in;
    endsequence

    sequence s_byte_inside;
        !bus_word_in && (comp_a_addr_in <= bus_addr_in) && (bus_addr_in <= comp_b_addr_in);
    endsequence

    sequence s_word_inside;
        bus_word_in && (comp_a_addr_in <= (bus_addr_in & WORD_ALIGN_MASK))
        && ((bus_addr_in & WORD_ALIGN_MASK) <= comp_b_addr_in);
    endsequence

    sequence s_open_filter;
        !data_mismatch_select_in && data_mask_high_in == '0 && data_mask_low_in == '0
        && (!comp_a_direction_qualify_enable_in || bus_read_in == comp_a_read_select_in);
    endsequence

    a_byte_inside: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        s_plain_range ##0 s_byte_inside ##0 s_open_filter |=> range_match_out)
        else $error("byte access inside range missed");
    a_word_aligned: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        s_plain_range ##0 s_word_inside ##0 s_open_filter |=> range_match_out)
        else $error("aligned word inside range missed");
    a_word_straddle: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (bus_word_in && !comp_a_tag_in
         && (bus_addr_in & WORD_ALIGN_MASK) < comp_a_addr_in) |=> !range_match_out)
        else $error("straddling word matched below range");
    a_tag_limits: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (bus_valid_in && comp_a_enable_in && comp_b_enable_in && comp_a_tag_in
         && !bus_word_in && (comp_a_addr_in & WORD_ALIGN_MASK) <= bus_addr_in
         && bus_addr_in <= (comp_b_addr_in | ~WORD_ALIGN_MASK))
        ##0 s_open_filter |=> range_match_out)
        else $error("tagged range not widened to words");
    a_diff_found: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        s_plain_range ##0 s_byte_inside
        ##0 (data_mismatch_select_in && !comp_a_direction_qualify_enable_in
             && ((bus_data_in ^ comp_a_data_in) & {data_mask_high_in, data_mask_low_in}) != '0)
        |=> range_match_out)
        else $error("masked difference not matched");
    a_diff_absent: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (data_mismatch_select_in
         && ((bus_data_in ^ comp_a_data_in) & {data_mask_high_in, data_mask_low_in}) == '0)
        |=> !range_match_out)
        else $error("difference match without masked difference");
    // b-side direction bits stay out of the antecedent on purpose
    a_dir_pass: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        s_plain_range ##0 s_byte_inside
        ##0 (!data_mismatch_select_in && data_mask_high_in == '0 && data_mask_low_in == '0
             && comp_a_direction_qualify_enable_in && bus_read_in == comp_a_read_select_in)
        |=> range_match_out)
        else $error("wanted direction refused");
    a_answer_source: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        range_match_out |-> $past(bus_valid_in))
        else $error("match without a bus cycle");
    a_force_untagged: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        force_request_out |-> range_match_out && !$past(comp_a_tag_in))
        else $error("force request on a tagged range");
endmodule
`default_nettype wire

// File: tb/dbcm_bus_model.sv
// Purpose: cpu bus model issuing one monitored bus cycle per call
// Assumes: requests change just after the rising edge
// Notes:   idle address, data and read lines show the inverse of the last value, word keeps it, never a stale hit
`default_nettype none
module dbcm_bus_model (
    input  wire logic        clk_in,
    output logic             valid_out,
    output logic [15:0]      addr_out,
    output logic [15:0]      data_out,
    output logic             read_out,
    output logic             word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_out = 1'b0;
        addr_out  = 16'h0000;
        data_out  = 16'h0000;
        read_out  = 1'b0;
        word_out  = 1'b0;
    end
    task automatic issue(input logic [15:0] a, d, input logic rd, wd);
        @(posedge clk_in);
        valid_out <= 1'b1;
        addr_out  <= a;
        data_out  <= d;
        read_out  <= rd;
        word_out  <= wd;
        @(posedge clk_in);
        valid_out <= 1'b0;
        addr_out  <= ~a;
        data_out  <= ~d;
        read_out  <= ~rd;
    endtask
endmodule
`default_nettype wire

// File: tb/debug_bus_comparator_match_tb.sv
// Purpose: self-checking bench for the range match block
// Assumes: answer one cycle after the taken edge
// Notes:   expectations come from the limits and masks set here
`default_nettype none
module debug_bus_comparator_match_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dbcm_pkg::*;
    logic clk_sys_in = 1'b0, srst_in = 1'b1, data_mismatch_select = 1'b0, ena = 1'b0, enb = 1'b0;
    logic rsa = 1'b0, qa = 1'b0, rsb = 1'b0, qb = 1'b0, access_size_compare_enable = 1'b0, ta = 1'b0;
    logic tb_ = 1'b0, bra = 1'b0, brb = 1'b0;
    logic [1:0]  sz = 2'h0;
    logic [7:0]  mh = 8'h00, ml = 8'h00;
    logic [15:0] al = 16'h0000, bl = 16'h0000, rf = 16'h0000;
    wire logic v, rd, wd, m_o, t_o, f_o, b_o;
    wire logic [15:0] ad, dt;
    int fail_count = 0, total_checks = 0;
    initial forever #20 clk_sys_in = ~clk_sys_in;
    dbcm_bus_model u_bus (.clk_in(clk_sys_in), .valid_out(v), .addr_out(ad),
        .data_out(dt), .read_out(rd), .word_out(wd));
    dbcm_match u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .bus_valid_in(v),
        .bus_addr_in(ad), .bus_data_in(dt), .bus_read_in(rd), .bus_word_in(wd),
        .bus_size_in(sz), .comp_a_addr_in(al), .comp_b_addr_in(bl), .comp_a_data_in(rf),
        .data_mask_high_in(mh), .data_mask_low_in(ml), .data_mismatch_select_in(data_mismatch_select),
        .comp_a_enable_in(ena), .comp_b_enable_in(enb), .comp_a_read_select_in(rsa),
        .comp_a_direction_qualify_enable_in(qa), .comp_b_read_select_in(rsb),
        .comp_b_direction_qualify_enable_in(qb), .access_size_compare_enable_in(access_size_compare_enable),
        .access_size_select_in(sz), .comp_a_tag_in(ta), .comp_b_tag_in(tb_),
        .comp_a_immediate_break_request_in(bra), .comp_b_immediate_break_request_in(brb),
        .range_match_out(m_o), .tag_request_out(t_o), .force_request_out(f_o),
        .break_request_out(b_o));
    task automatic chk(input string n, input logic e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    // ---------------------------------------------------------------
    // one bus cycle, then all four outputs in the answer cycle
    // ---------------------------------------------------------------
    task automatic probe(input logic [15:0] a, d, input logic r, w, e);
        u_bus.issue(a, d, r, w);
        #1;
        chk("match", e, m_o);
        chk("tag", e & ta, t_o);
        chk("force", e & ~ta, f_o);
        chk("break", e & bra, b_o);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: tests need 67 cycles, far below the 10000-cycle limit
    initial begin
        #400000;
        fail_count++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        al <= 16'h1000;
        bl <= 16'h10ff;
        ena <= 1'b1;
        enb <= 1'b1;
        probe(16'h1000, 16'h1234, 1'b1, 1'b0, 1'b1);
        probe(16'h0fff, 16'h1234, 1'b1, 1'b0, 1'b0);
        probe(16'h10ff, 16'h0000, 1'b0, 1'b0, 1'b1);
        probe(16'h1100, 16'h0000, 1'b1, 1'b0, 1'b0);
        @(posedge clk_sys_in);
        enb <= 1'b0;
        probe(16'h1000, 16'h0000, 1'b1, 1'b0, 1'b0);
        $display("test range done");
        @(posedge clk_sys_in);
        enb <= 1'b1;
        mh <= 8'hff;
        rf <= 16'h5500;
        probe(16'h1050, 16'h55aa, 1'b1, 1'b0, 1'b1);
        probe(16'h1050, 16'h54aa, 1'b1, 1'b0, 1'b0);
        @(posedge clk_sys_in);
        data_mismatch_select <= 1'b1;
        mh <= 8'h00;
        ml <= 8'h01;
        rf <= 16'h0000;
        probe(16'h1050, 16'h0001, 1'b1, 1'b0, 1'b1);
        probe(16'h1050, 16'hff00, 1'b1, 1'b0, 1'b0);
        @(posedge clk_sys_in);
        ml <= 8'h00;
        probe(16'h1050, 16'hffff, 1'b1, 1'b0, 1'b0);
        $display("test data done");
        @(posedge clk_sys_in);
        data_mismatch_select <= 1'b0;
        qa <= 1'b1;
        rsa <= 1'b1;
        qb <= 1'b1;
        access_size_compare_enable <= 1'b1;
        sz <= 2'h3;
        tb_ <= 1'b1;
        brb <= 1'b1;
        probe(16'h1050, 16'h0000, 1'b1, 1'b0, 1'b1);
        probe(16'h1050, 16'h0000, 1'b0, 1'b0, 1'b0);
        $display("test qualify done");
        @(posedge clk_sys_in);
        ta <= 1'b1;
        bra <= 1'b1;
        tb_ <= 1'b0;
        al <= 16'h1001;
        bl <= 16'h10fe;
        probe(16'h1000, 16'h0000, 1'b1, 1'b0, 1'b1);
        probe(16'h10ff, 16'h0000, 1'b1, 1'b0, 1'b1);
        @(posedge clk_sys_in);
        ta <= 1'b0;
        probe(16'h1000, 16'h0000, 1'b1, 1'b0, 1'b0);
        probe(16'h1001, 16'h0000, 1'b1, 1'b1, 1'b0);
        probe(16'h1003, 16'h0000, 1'b1, 1'b1, 1'b1);
        $display("test tag and word done");
        // reset in mid-run swallows a hit in flight, then matching resumes
        @(posedge clk_sys_in);
        srst_in <= 1'b1;
        probe(16'h1003, 16'h0000, 1'b1, 1'b1, 1'b0);
        @(posedge clk_sys_in);
        srst_in <= 1'b0;
        probe(16'h1003, 16'h0000, 1'b1, 1'b1, 1'b1);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
